// *** verilog/rim_regs.sv ***
// Summary of operation
// - An interrupt wake with the global enable set loads the pc low byte with the vector.
// - A wake from sleep sets the flag bit of the source that woke the device.
// - Unimplemented bit positions always read as zero.
// - Port D and E data and direction registers exist only with the parallel slave port.
// - A wake keeps all contents except pc, condition status bits and waking flags.
// - Resets clear pc, comparator, reference and peripheral bits, set prescale and directions.
// - Status and power status cause bits follow the actual reset condition.
// - A parity-error reset clears the parity flag, which stays clear until software or a power-on reset sets it.
// - A power-on reset clears the power-on flag; other causes leave it alone.
`timescale 1ns/1ps
`default_nettype none
module rim_regs
  import rim_pkg::*;
#(
  parameter bit HAS_PSP = 1'b1
) (
  input  wire logic          CLK_SYS,
  input  wire logic          RESETN,
  input  wire rim_cause_t    RESET_CAUSE,
  input  wire logic          SLEEP_REQ,
  input  wire rim_wake_src_t WAKE_IRQ,
  input  wire logic          WAKE_WDT,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [9:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  output logic               SLEEPING,
  output logic [7:0]         DIR_A,
  output logic [7:0]         DIR_B,
  output logic [7:0]         PRESCALE_CFG
);

  // ========================================================================
  // Storage
  logic [7:0] regs_r [0:255];
  logic [7:0] sel_mask;
  logic [7:0] rd_byte;
  logic [7:0] pc_low_r;
  logic [7:0] status_r;
  logic [7:0] power_r;
  logic [7:0] irq_ctl_r;
  logic [7:0] pirf_r;
  rim_state_t state_r;
  logic       ack_r;
  logic [1:0] wake_st_r;
  logic       in_reset_r;

  wire logic [7:0] idx   = PADDR[9:2];
  wire logic       wr_en = PSEL && PENABLE && PWRITE && ack_r;
  wire logic       wake_irq = (state_r == RIM_ST_SLEEP) &&
                              ((|WAKE_IRQ.irq_bits) || (|WAKE_IRQ.periph_bits));
  wire logic       wake_wdt = (state_r == RIM_ST_SLEEP) && WAKE_WDT && !wake_irq;
  // Writes that meet a wake cycle are dropped so the wake column stays exact
  wire logic       wr_ok    = wr_en && (sel_mask != RST_ZERO) && !wake_irq && !wake_wdt;
  wire logic       col_load = in_reset_r && RESETN;

  // ========================================================================
  // Implemented-bit masks
  // One decoder for the addressed index replaces a full table of masks
  always_comb begin
    if (idx == IDX_TMR) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_PCL) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_STAT) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_PTR) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_PA) begin
      sel_mask = MSK_6;
    end else if (idx == IDX_PB) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_PC) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_PD) begin
      sel_mask = HAS_PSP ? RST_ONES : RST_ZERO;
    end else if (idx == IDX_PE) begin
      sel_mask = HAS_PSP ? MSK_3 : RST_ZERO;
    end else if (idx == IDX_PCH) begin
      sel_mask = MSK_5;
    end else if (idx == IDX_IRQ) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_PIRF) begin
      sel_mask = MSK_2;
    end else if (idx == IDX_CMP) begin
      sel_mask = MSK_6;
    end else if (idx == IDX_OPT) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_DA) begin
      sel_mask = MSK_6;
    end else if (idx == IDX_DB) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_DC) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_DD) begin
      sel_mask = HAS_PSP ? RST_ONES : RST_ZERO;
    end else if (idx == IDX_DE) begin
      sel_mask = HAS_PSP ? MSK_DE : RST_ZERO;
    end else if (idx == IDX_PIEN) begin
      sel_mask = MSK_2;
    end else if (idx == IDX_PWR) begin
      sel_mask = MSK_4;
    end else if (idx == IDX_VREF) begin
      sel_mask = MSK_VREF;
    end else if (idx == IDX_ACC) begin
      sel_mask = RST_ONES;
    end else if (idx == IDX_WAKE) begin
      sel_mask = RST_ONES;
    end else begin
      sel_mask = RST_ZERO;
    end
  end

  // ========================================================================
  // Read selection
  always_comb begin
    if (idx == IDX_PCL) begin
      rd_byte = pc_low_r;
    end else if (idx == IDX_STAT) begin
      rd_byte = status_r;
    end else if (idx == IDX_PWR) begin
      rd_byte = power_r;
    end else if (idx == IDX_IRQ) begin
      rd_byte = irq_ctl_r;
    end else if (idx == IDX_PIRF) begin
      rd_byte = pirf_r;
    end else begin
      rd_byte = regs_r[idx];
    end
  end

  // ========================================================================
  // APB slave: one wait state, unmapped reads zero with error
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= PSEL && PENABLE && !ack_r;
    end
  end

  assign PREADY = ack_r;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !ack_r) begin
      PSLVERR <= (idx != IDX_WST) && (sel_mask == RST_ZERO);
      if (idx == IDX_WST) begin
        PRDATA <= {30'h0000_0000, wake_st_r};
      end else begin
        PRDATA <= {24'h00_0000, rd_byte & sel_mask};
      end
    end else begin
      PSLVERR <= 1'b0;
    end
  end

  // ========================================================================
  // Sleep state machine
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      state_r <= RIM_ST_RESET;
    end else begin
      case (state_r)
        RIM_ST_RESET: begin
          state_r <= RIM_ST_RUN;
        end
        RIM_ST_RUN: begin
          if (SLEEP_REQ) state_r <= RIM_ST_SLEEP;
        end
        RIM_ST_SLEEP: begin
          if (wake_irq || wake_wdt) state_r <= RIM_ST_RUN;
        end
        default: begin
          state_r <= RIM_ST_RESET;
        end
      endcase
    end
  end

  assign SLEEPING = (state_r == RIM_ST_SLEEP);

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      wake_st_r <= 2'b00;
    end else if (wake_irq) begin
      wake_st_r <= 2'b01;
    end else if (wake_wdt) begin
      wake_st_r <= 2'b10;
    end
  end

  // ========================================================================
  // Register contents
  // Reset columns are applied on the first edge after release, because a
  // synchronous reset flop may only load constants; the cause is sampled then
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
    end
  end

  // ========================================================================
  // Plain registers: contents persist through sleep and wake
  always_ff @(posedge CLK_SYS) begin
    if (col_load) begin
      regs_r[IDX_PCH]  <= RST_ZERO;
      regs_r[IDX_CMP]  <= RST_ZERO;
      regs_r[IDX_VREF] <= RST_ZERO;
      regs_r[IDX_PIEN] <= RST_ZERO;
      regs_r[IDX_OPT]  <= RST_ONES;
      regs_r[IDX_DA]   <= RST_ONES;
      regs_r[IDX_DB]   <= RST_ONES;
      regs_r[IDX_DC]   <= RST_ONES;
      regs_r[IDX_DD]   <= RST_ONES;
      regs_r[IDX_DE]   <= RST_DE;
      regs_r[IDX_PA]   <= regs_r[IDX_PA] & ~MSK_4;
    end else if (wr_ok) begin
      regs_r[idx] <= PWDATA[7:0] & sel_mask;
    end
  end

  // ========================================================================
  // Program counter low byte
  always_ff @(posedge CLK_SYS) begin
    if (col_load) begin
      pc_low_r <= RST_ZERO;
    end else if (wake_irq) begin
      if (irq_ctl_r[IRQ_GIE]) begin
        pc_low_r <= IRQ_VECTOR;
      end else begin
        pc_low_r <= pc_low_r + 8'h01;
      end
    end else if (wake_wdt) begin
      pc_low_r <= pc_low_r + 8'h01;
    end else if (wr_ok && idx == IDX_PCL) begin
      pc_low_r <= PWDATA[7:0];
    end
  end

  // ========================================================================
  // Core status: time-out and power-down bits follow the condition
  always_ff @(posedge CLK_SYS) begin
    if (col_load) begin
      case (RESET_CAUSE)
        RIM_CAUSE_POR, RIM_CAUSE_BOR, RIM_CAUSE_PER: begin
          status_r <= {3'h0, 2'b11, status_r[2:0]};
        end
        RIM_CAUSE_MASTER_CLEAR_PIN_SLEEP: begin
          status_r <= {3'h0, 2'b10, status_r[2:0]};
        end
        RIM_CAUSE_WDT: begin
          status_r <= {3'h0, 2'b01, status_r[2:0]};
        end
        default: begin
          status_r <= {3'h0, status_r[4:0]};
        end
      endcase
    end else if (wake_irq) begin
      status_r[STAT_TO] <= 1'b1;
      status_r[STAT_PD] <= 1'b0;
    end else if (wake_wdt) begin
      status_r[STAT_TO] <= 1'b0;
      status_r[STAT_PD] <= 1'b0;
    end else if (wr_ok && idx == IDX_STAT) begin
      status_r <= PWDATA[7:0];
    end
  end

  // ========================================================================
  // Power status: each cause touches only its own flag, except power-on, which also sets the parity flag
  always_ff @(posedge CLK_SYS) begin
    if (col_load) begin
      case (RESET_CAUSE)
        RIM_CAUSE_POR: begin
          power_r[PWR_PO] <= 1'b0;
          power_r[PWR_PE] <= 1'b1;
        end
        RIM_CAUSE_BOR: begin
          power_r[PWR_BO] <= 1'b0;
        end
        RIM_CAUSE_PER: begin
          power_r[PWR_PE] <= 1'b0;
        end
        default: begin
          power_r <= power_r;
        end
      endcase
    end else if (wr_ok && idx == IDX_PWR) begin
      // The parity flag is set here and by a power-on reset, so it stays clear until one of those
      power_r <= PWDATA[7:0] & MSK_4;
    end
  end

  // ========================================================================
  // Interrupt control: waking sources leave their flag set
  always_ff @(posedge CLK_SYS) begin
    if (col_load) begin
      irq_ctl_r <= {7'h00, irq_ctl_r[0]};
    end else if (wake_irq) begin
      irq_ctl_r <= irq_ctl_r | WAKE_IRQ.irq_bits;
    end else if (wr_ok && idx == IDX_IRQ) begin
      irq_ctl_r <= PWDATA[7:0];
    end
  end

  // ========================================================================
  // Peripheral interrupt flags
  always_ff @(posedge CLK_SYS) begin
    if (col_load) begin
      pirf_r <= RST_ZERO;
    end else if (wake_irq) begin
      pirf_r <= pirf_r | {6'h00, WAKE_IRQ.periph_bits};
    end else if (wr_ok && idx == IDX_PIRF) begin
      pirf_r <= PWDATA[7:0] & MSK_2;
    end
  end

  // ========================================================================
  // Outputs
  // Unused direction A bits stay low even while reset is held
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      DIR_A <= MSK_6;
    end else begin
      DIR_A <= regs_r[IDX_DA] & MSK_6;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      DIR_B <= RST_ONES;
    end else begin
      DIR_B <= regs_r[IDX_DB];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PRESCALE_CFG <= RST_ONES;
    end else begin
      PRESCALE_CFG <= regs_r[IDX_OPT];
    end
  end

endmodule : rim_regs
`default_nettype wire

// *** verilog/rim_pkg.sv ***
// ==========================================================================
// Register map constants
package rim_pkg;

  // APB byte addresses: printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is index*4
  localparam logic [7:0] IDX_INDIRECT_DATA_PORT   = 8'h00;
  localparam logic [7:0] IDX_TMR    = 8'h01;
  localparam logic [7:0] IDX_PCL    = 8'h02;
  localparam logic [7:0] IDX_STAT   = 8'h03;
  localparam logic [7:0] IDX_PTR    = 8'h04;
  localparam logic [7:0] IDX_PA     = 8'h05;
  localparam logic [7:0] IDX_PB     = 8'h06;
  localparam logic [7:0] IDX_PC     = 8'h07;
  localparam logic [7:0] IDX_PD     = 8'h08;
  localparam logic [7:0] IDX_PE     = 8'h09;
  localparam logic [7:0] IDX_PCH    = 8'h0A;
  localparam logic [7:0] IDX_IRQ    = 8'h0B;
  localparam logic [7:0] IDX_PIRF   = 8'h0C;
  localparam logic [7:0] IDX_CMP    = 8'h1F;
  localparam logic [7:0] IDX_OPT    = 8'h81;
  localparam logic [7:0] IDX_DA     = 8'h85;
  localparam logic [7:0] IDX_DB     = 8'h86;
  localparam logic [7:0] IDX_DC     = 8'h87;
  localparam logic [7:0] IDX_DD     = 8'h88;
  localparam logic [7:0] IDX_DE     = 8'h89;
  localparam logic [7:0] IDX_PIEN   = 8'h8C;
  localparam logic [7:0] IDX_PWR    = 8'h8E;
  localparam logic [7:0] IDX_VREF   = 8'h9F;
  // Own registers: accumulator, wake control, wake status
  localparam logic [7:0] IDX_ACC    = 8'hC0;
  localparam logic [7:0] IDX_WAKE   = 8'hC1;
  localparam logic [7:0] IDX_WST    = 8'hC2;

  // Reset values and implemented-bit masks
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_ONES   = 8'hFF;
  localparam logic [7:0] RST_DE     = 8'h07;
  localparam logic [7:0] MSK_6      = 8'h3F;
  localparam logic [7:0] MSK_5      = 8'h1F;
  localparam logic [7:0] MSK_3      = 8'h07;
  localparam logic [7:0] MSK_2      = 8'h03;
  localparam logic [7:0] MSK_4      = 8'h0F;
  localparam logic [7:0] MSK_DE     = 8'hF7;
  localparam logic [7:0] MSK_VREF   = 8'hEF;
  localparam logic [7:0] IRQ_VECTOR = 8'h04;

  // Field positions
  localparam int STAT_TO   = 4;
  localparam int STAT_PD   = 3;
  localparam int PWR_BO    = 0;
  localparam int PWR_PO    = 1;
  localparam int PWR_PE    = 2;
  localparam int IRQ_GIE   = 7;

  typedef enum logic [2:0] {
    RIM_CAUSE_POR,
    RIM_CAUSE_BOR,
    RIM_CAUSE_PER,
    RIM_CAUSE_MASTER_CLEAR_PIN_RUN,
    RIM_CAUSE_MASTER_CLEAR_PIN_SLEEP,
    RIM_CAUSE_WDT
  } rim_cause_t;

  typedef enum logic [1:0] {
    RIM_ST_RESET,
    RIM_ST_RUN,
    RIM_ST_SLEEP
  } rim_state_t;

  typedef struct packed {
    logic [7:0] irq_bits;
    logic [1:0] periph_bits;
  } rim_wake_src_t;

endpackage : rim_pkg

// *** dv/rim_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module rim_regs_checker
  import rim_pkg::*;
(
  input wire logic          CLK_SYS,
  input wire logic          RESETN,
  input wire rim_cause_t    RESET_CAUSE,
  input wire logic          SLEEP_REQ,
  input wire rim_wake_src_t WAKE_IRQ,
  input wire logic          WAKE_WDT,
  input wire logic          PSEL,
  input wire logic          PENABLE,
  input wire logic          PWRITE,
  input wire logic [9:0]    PADDR,
  input wire logic [31:0]   PWDATA,
  input wire logic [31:0]   PRDATA,
  input wire logic          PREADY,
  input wire logic          PSLVERR,
  input wire logic          SLEEPING,
  input wire logic [7:0]    DIR_A,
  input wire logic [7:0]    DIR_B,
  input wire logic [7:0]    PRESCALE_CFG
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // ==========
  // Bus answers
  chk_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no ready after one wait state");
  chk_err_zero: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == '0))
    else $error("refused read not zero");
  chk_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == '0)
    else $error("read data upper bits set");
  // ==========
  // Register outputs
  chk_dir_unimpl: assert property ($past(RESETN) && $past(RESETN, 2) |-> DIR_A[7:6] == 2'b00)
    else $error("direction A unused bits set");
  chk_dir_follow: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == {IDX_DA, 2'b00}
    |-> ##2 (DIR_A == {2'b00, $past(PWDATA[5:0], 2)}))
    else $error("direction A write not seen");
  chk_reset_cols: assert property ($rose(RESETN) |-> ##2 (DIR_A == 8'h3F && DIR_B == 8'hFF
    && PRESCALE_CFG == 8'hFF))
    else $error("reset column not applied");
  // ==========
  // Sleep and wake
  chk_sleep_entry: assert property ($past(RESETN, 2) && !SLEEPING && SLEEP_REQ |=> SLEEPING)
    else $error("sleep not entered");
  chk_wake_exit: assert property (SLEEPING && (WAKE_WDT || WAKE_IRQ != '0) |=> !SLEEPING)
    else $error("wake ignored");
  chk_wake_keep: assert property ($fell(SLEEPING) |-> ##1 ($stable(DIR_A) && $stable(DIR_B)
    && $stable(PRESCALE_CFG)))
    else $error("wake changed registers");
  cov_wdt_wake: cover property (SLEEPING && WAKE_WDT);
  cov_irq_wake: cover property (SLEEPING && WAKE_IRQ != '0);
  cov_refused: cover property (PSLVERR);
endmodule : rim_regs_checker
bind rim_regs rim_regs_checker u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .RESET_CAUSE(RESET_CAUSE), .SLEEP_REQ(SLEEP_REQ), .WAKE_IRQ(WAKE_IRQ), .WAKE_WDT(WAKE_WDT),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEPING(SLEEPING),
  .DIR_A(DIR_A), .DIR_B(DIR_B), .PRESCALE_CFG(PRESCALE_CFG));
`default_nettype wire

// *** dv/test_reset_init_register_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_reset_init_register_map
  import rim_pkg::*;
;
  logic          clk = 0, resetn = 0, sleep_req = 0, wake_wdt = 0;
  logic          psel = 0, penable = 0, pwrite = 0, pready, pslverr, sleeping, pslverr_np;
  logic [31:0]   prdata_np;
  rim_cause_t    cause = RIM_CAUSE_POR;
  rim_wake_src_t wake_irq = '0;
  logic [9:0]    paddr = '0;
  logic [31:0]   pwdata = '0, prdata;
  logic [7:0]    r;
  logic [32:0]   exp_q[$], msk_q[$];
  int            err_total = 0, total_checks = 0, cyc = 0;
  // Reset column after power-on, then per-cause status and power flags
  logic [7:0]    ri[12] = '{IDX_OPT, IDX_DA, IDX_DB, IDX_DC, IDX_DD, IDX_DE, IDX_PCL, IDX_CMP,
                            IDX_VREF, IDX_PIRF, IDX_PIEN, IDX_PCH};
  logic [7:0]    rv[12] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h00};
  logic [7:0]    sv[6] = '{8'h18, 8'h18, 8'h18, 8'h00, 8'h10, 8'h08};
  logic [7:0]    sm[6] = '{8'hF8, 8'hF8, 8'hF8, 8'hE0, 8'hF8, 8'hF8};
  logic [7:0]    pv[6] = '{8'h04, 8'h06, 8'h02, 8'h07, 8'h07, 8'h07};
  logic [7:0]    pm[6] = '{8'h06, 8'h07, 8'h06, 8'h07, 8'h07, 8'h07};

  rim_regs uut (.CLK_SYS(clk), .RESETN(resetn), .RESET_CAUSE(cause), .SLEEP_REQ(sleep_req),
    .WAKE_IRQ(wake_irq), .WAKE_WDT(wake_wdt), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SLEEPING(sleeping), .DIR_A(), .DIR_B(), .PRESCALE_CFG());
  // Variant without the parallel slave port shares the bus and is checked on it
  rim_regs #(.HAS_PSP(1'b0)) uut_nopsp (.CLK_SYS(clk), .RESETN(resetn), .RESET_CAUSE(cause),
    .SLEEP_REQ(sleep_req), .WAKE_IRQ(wake_irq), .WAKE_WDT(wake_wdt), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata_np),
    .PREADY(), .PSLVERR(pslverr_np), .SLEEPING(), .DIR_A(), .DIR_B(), .PRESCALE_CFG());

  initial forever #5 clk = ~clk;
  // ==========
  // Tasks
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [32:0] e = '0, input logic [32:0] m = '1);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= 32'(d);
    if (!wr) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] idx, input logic [7:0] v, input logic [7:0] m = 8'hFF);
    apb(1'b0, idx, 8'h00, {25'h0, v}, {25'h1FF_FFFF, m});
  endtask : rd
  task automatic rst(input rim_cause_t c);
    @(posedge clk);
    resetn <= 1'b0;
    cause <= c;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rst
  task automatic wake(input logic irq);
    sleep_req <= 1'b1;
    @(posedge clk);
    while (sleeping !== 1'b1) @(posedge clk);
    sleep_req <= 1'b0;
    wake_irq <= irq ? 10'h004 : 10'h000;
    wake_wdt <= !irq;
    @(posedge clk);
    wake_irq <= '0;
    wake_wdt <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : wake
  // ==========
  // Monitor and timeout
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk('x, '0);
      else chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
      if (paddr[9:2] == IDX_DD) chk({pslverr_np, prdata_np}, 33'h1_0000_0000);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end
  // ==========
  // Scenarios
  initial begin
    r = $urandom(86);
    rst(RIM_CAUSE_POR);
    for (int i = 0; i < 12; i++) rd(ri[i], rv[i]);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, IDX_PWR, 8'h07);
      rst(rim_cause_t'(c));
      rd(IDX_STAT, sv[c], sm[c]);
      rd(IDX_PWR, pv[c], pm[c]);
      rd(IDX_DA, 8'h3F);
    end
    r = $urandom;
    apb(1'b1, IDX_DA, r);
    rd(IDX_DA, r & 8'h3F);
    apb(1'b1, IDX_PCH, 8'hFF);
    rd(IDX_PCH, 8'h1F);
    apb(1'b0, 8'h50, 8'h00, 33'h1_0000_0000);
    apb(1'b1, IDX_OPT, r);
    apb(1'b1, IDX_PCL, r);
    apb(1'b1, IDX_IRQ, 8'h80);
    wake(1'b1);
    rd(IDX_PCL, 8'h04);
    rd(IDX_IRQ, 8'h01, 8'h01);
    rd(IDX_STAT, 8'h10, 8'h18);
    rd(IDX_OPT, r);
    apb(1'b1, IDX_PCL, r);
    wake(1'b0);
    rd(IDX_PCL, r + 8'h01);
    rd(IDX_STAT, 8'h00, 8'h18);
    rd(IDX_DA, r & 8'h3F);
    end_sim;
  end
endmodule : test_reset_init_register_map
`default_nettype wire
